// [hw/pscc_top.sv]
`timescale 1ns/100ps
`default_nettype none
module pscc_top
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// per-channel switch controls
	output logic [3:0] measure_select_hi_o,
	output logic [3:0] measure_select_lo_o,
	output logic [3:0] measure_output_switch_open_o,
	output logic [3:0] force_input_select_o,
	output logic [3:0] system_force_connect_o,
	output logic [3:0] system_sense_connect_o,
	output logic [3:0] clamp_enable_o,
	output logic [3:0] comparator_output_enable_o,
	// global
	output logic comparator_bias_enable_o
);
	// ==========================================
	// bus slave
	pscc_pkg::pscc_bus_t bus_reg;
	logic req;
	logic wr_chan;
	logic wr_sys;
	logic wr_rdsel;
	logic [3:0] chan_mask;
	logic [1:0] rdsel_reg;
	logic [31:0] rdata_next;

	assign req = wb_cyc_i && wb_stb_i && (bus_reg == pscc_pkg::PSCC_IDLE);
	assign wr_chan = req && wb_we_i && wb_sel_i[1] && (wb_adr_i == pscc_pkg::CHAN_OFS);
	assign wr_sys = req && wb_we_i && wb_sel_i[1] && (wb_adr_i == pscc_pkg::SYS_OFS);
	assign wr_rdsel = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == pscc_pkg::RDSEL_OFS);
	// channel address
	// without lane 3 no channel is addressed, so the write changes nothing
	assign chan_mask = wb_sel_i[3] ? wb_dat_i[pscc_pkg::CH_ADDR_LSB +: 4] : 4'h0;
	assign wb_ack_o = (bus_reg == pscc_pkg::PSCC_ACK);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bus_reg <= pscc_pkg::PSCC_IDLE;
		else
		begin
			case (bus_reg)
				pscc_pkg::PSCC_IDLE:
					if (wb_cyc_i && wb_stb_i)
						bus_reg <= pscc_pkg::PSCC_ACK;
				pscc_pkg::PSCC_ACK:
					bus_reg <= pscc_pkg::PSCC_IDLE;
				default:
					bus_reg <= pscc_pkg::PSCC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdsel_reg <= pscc_pkg::RDSEL_RST;
		else if (wr_rdsel)
			rdsel_reg <= wb_dat_i[1:0];
	end

	// ==========================================
	// channel state
	logic [3:0] mhi_reg;
	logic [3:0] mlo_reg;
	logic [3:0] fin_reg;
	logic [3:0] sf_reg;
	logic [3:0] ss_reg;
	logic [3:0] clamp_reg;
	logic [3:0] cmpoe_reg;
	logic [3:0] hiz_reg;
	logic bias_reg;

	genvar g;
	generate
		for (g = 0; g < pscc_pkg::NCH; g++)
		begin : g_ch
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					mhi_reg[g] <= pscc_pkg::MEAS_RST[1];
					mlo_reg[g] <= pscc_pkg::MEAS_RST[0];
					hiz_reg[g] <= 1'b1;
					fin_reg[g] <= 1'b0;
					sf_reg[g] <= 1'b0;
					ss_reg[g] <= 1'b0;
				end
				else if (wr_chan && chan_mask[g])
				begin
					mhi_reg[g] <= wb_dat_i[pscc_pkg::MEAS_HI_BIT];
					mlo_reg[g] <= wb_dat_i[pscc_pkg::MEAS_LO_BIT];
					hiz_reg[g] <= wb_dat_i[pscc_pkg::MEAS_HI_BIT] && wb_dat_i[pscc_pkg::MEAS_LO_BIT];
					fin_reg[g] <= wb_dat_i[pscc_pkg::FIN_BIT];
					sf_reg[g] <= wb_dat_i[pscc_pkg::SF_BIT];
					ss_reg[g] <= wb_dat_i[pscc_pkg::SS_BIT];
				end
			end

			// shared state
			// system control writes reach every channel; later write wins
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					clamp_reg[g] <= 1'b0;
					cmpoe_reg[g] <= 1'b0;
				end
				else if (wr_sys || (wr_chan && chan_mask[g]))
				begin
					clamp_reg[g] <= wb_dat_i[pscc_pkg::CLAMP_BIT];
					cmpoe_reg[g] <= wb_dat_i[pscc_pkg::CMPOE_BIT];
				end
			end
		end
	endgenerate

	// bias enable kept
	// bias is only stored; software must set it before comparators work
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bias_reg <= 1'b0;
		else if (wr_sys)
			bias_reg <= wb_dat_i[pscc_pkg::BIAS_BIT];
	end

	// ==========================================
	// read back
	// shared read-back
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		case (wb_adr_i)
			pscc_pkg::CHAN_OFS:
			begin
				rdata_next[pscc_pkg::MEAS_HI_BIT] = mhi_reg[rdsel_reg];
				rdata_next[pscc_pkg::MEAS_LO_BIT] = mlo_reg[rdsel_reg];
				rdata_next[pscc_pkg::FIN_BIT] = fin_reg[rdsel_reg];
				rdata_next[pscc_pkg::SF_BIT] = sf_reg[rdsel_reg];
				rdata_next[pscc_pkg::SS_BIT] = ss_reg[rdsel_reg];
				rdata_next[pscc_pkg::CLAMP_BIT] = clamp_reg[rdsel_reg];
				rdata_next[pscc_pkg::CMPOE_BIT] = cmpoe_reg[rdsel_reg];
			end
			pscc_pkg::SYS_OFS:
			begin
				rdata_next[pscc_pkg::BIAS_BIT] = bias_reg;
				rdata_next[pscc_pkg::CLAMP_BIT] = clamp_reg[rdsel_reg];
				rdata_next[pscc_pkg::CMPOE_BIT] = cmpoe_reg[rdsel_reg];
			end
			pscc_pkg::RDSEL_OFS:
				rdata_next[1:0] = rdsel_reg;
			default:
				rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (req)
			wb_dat_o <= rdata_next;
	end

	assign measure_select_hi_o = mhi_reg;
	assign measure_select_lo_o = mlo_reg;
	assign measure_output_switch_open_o = hiz_reg;
	assign force_input_select_o = fin_reg;
	assign system_force_connect_o = sf_reg;
	assign system_sense_connect_o = ss_reg;
	assign clamp_enable_o = clamp_reg;
	assign comparator_output_enable_o = cmpoe_reg;
	assign comparator_bias_enable_o = bias_reg;

	// ==========================================
	// checks
	sequence s_chan_wr;
		wr_chan && chan_mask[0];
	endsequence

	sequence s_sys_wr;
		wr_sys && !wr_chan;
	endsequence

	a_hiz_code: assert property (@(posedge clk_i) disable iff (rst_i)
		measure_output_switch_open_o == (mhi_reg & mlo_reg))
		else $error("measure switch disagrees with select code");

	a_meas_route: assert property (@(posedge clk_i) disable iff (rst_i)
		s_chan_wr |=>
			(measure_select_hi_o[0] == $past(wb_dat_i[pscc_pkg::MEAS_HI_BIT]))
			&& (measure_select_lo_o[0] == $past(wb_dat_i[pscc_pkg::MEAS_LO_BIT])))
		else $error("measure select not loaded");

	a_fin_load: assert property (@(posedge clk_i) disable iff (rst_i)
		s_chan_wr |=> force_input_select_o[0] == $past(wb_dat_i[pscc_pkg::FIN_BIT]))
		else $error("force input select not loaded");

	a_sys_lines: assert property (@(posedge clk_i) disable iff (rst_i)
		s_chan_wr |=>
			(system_force_connect_o[0] == $past(wb_dat_i[pscc_pkg::SF_BIT]))
			&& (system_sense_connect_o[0] == $past(wb_dat_i[pscc_pkg::SS_BIT])))
		else $error("shared line connects not loaded");

	a_unaddr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_chan && !chan_mask[1]) |=> $stable(system_force_connect_o[1])
			&& $stable(system_sense_connect_o[1]))
		else $error("unaddressed channel changed");

	a_clamp_wr: assert property (@(posedge clk_i) disable iff (rst_i)
		s_chan_wr |=> clamp_enable_o[0] == $past(wb_dat_i[pscc_pkg::CLAMP_BIT]))
		else $error("clamp enable not loaded");

	a_clamp_last: assert property (@(posedge clk_i) disable iff (rst_i)
		s_sys_wr |=> clamp_enable_o == {4{$past(wb_dat_i[pscc_pkg::CLAMP_BIT])}})
		else $error("system write lost on clamp");

	a_cmp_off: assert property (@(posedge clk_i)
		rst_i |=> comparator_output_enable_o == 4'h0)
		else $error("comparator enabled after reset");

	a_cmp_shared: assert property (@(posedge clk_i) disable iff (rst_i)
		s_sys_wr ##1 (!wr_sys && !wr_chan) |=> comparator_output_enable_o[2]
			== $past(wb_dat_i[pscc_pkg::CMPOE_BIT], 2))
		else $error("comparator enable not shared");

	a_cmp_rdback: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == pscc_pkg::SYS_OFS) |=>
			wb_ack_o && wb_dat_o[pscc_pkg::CMPOE_BIT] == $past(cmpoe_reg[rdsel_reg]))
		else $error("comparator read-back wrong");

	a_multi_wr: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_chan && chan_mask == 4'hf) |=>
			(force_input_select_o == {4{$past(wb_dat_i[pscc_pkg::FIN_BIT])}})
			&& (clamp_enable_o == {4{$past(wb_dat_i[pscc_pkg::CLAMP_BIT])}}))
		else $error("multi-channel write not uniform");
endmodule : pscc_top
`default_nettype wire

// [hw/pscc_pkg.sv]
package pscc_pkg;
	// ==========================================
	// geometry
	localparam int NCH = 4;
	localparam logic [3:0] ADDR_W = 4'h4;
	// ==========================================
	// register byte addresses (word index in adr[3:2])
	localparam logic [3:0] CHAN_OFS = 4'h0;
	localparam logic [3:0] SYS_OFS = 4'h4;
	localparam logic [3:0] RDSEL_OFS = 4'h8;
	// ==========================================
	// channel register fields
	localparam int CH_ADDR_LSB = 24;
	localparam int MEAS_HI_BIT = 14;
	localparam int MEAS_LO_BIT = 13;
	localparam int FIN_BIT = 12;
	localparam int SF_BIT = 11;
	localparam int SS_BIT = 10;
	localparam int CLAMP_BIT = 9;
	localparam int CMPOE_BIT = 8;
	// system control fields
	localparam int BIAS_BIT = 13;
	// ==========================================
	// measure routing codes and reset values
	localparam logic [1:0] MEAS_ISENSE = 2'h0;
	localparam logic [1:0] MEAS_VSENSE = 2'h1;
	localparam logic [1:0] MEAS_TEMP = 2'h2;
	localparam logic [1:0] MEAS_HIZ = 2'h3;
	localparam logic [1:0] MEAS_RST = 2'h3;
	localparam logic [1:0] RDSEL_RST = 2'h0;
	// ==========================================
	// bus answer state
	typedef enum logic [1:0] {
		PSCC_IDLE = 2'b01,
		PSCC_ACK = 2'b10
	} pscc_bus_t;
endpackage : pscc_pkg

// [verification/pscc_top_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module pscc_top_tb_top;
	// ==========================================
	// stimulus and observed signals
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [3:0] hi_o, lo_o, open_o, fin_o, sf_o, ss_o, cl_o, oe_o;
	logic bias_o;
	logic [3:0] e_hi = 4'hf, e_lo = 4'hf, e_fin = 4'h0, e_sf = 4'h0, e_ss = 4'h0;
	logic [3:0] e_cl = 4'h0, e_oe = 4'h0, m;
	logic e_bias = 1'b0;
	logic [31:0] d, rd;
	logic [1:0] ch;
	int failures = 0;
	int comparisons = 0;
	int i;
	always #4 clk_i = ~clk_i;
	pscc_top dut_u
	(
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .measure_select_hi_o(hi_o),
		.measure_select_lo_o(lo_o), .measure_output_switch_open_o(open_o),
		.force_input_select_o(fin_o), .system_force_connect_o(sf_o),
		.system_sense_connect_o(ss_o), .clamp_enable_o(cl_o),
		.comparator_output_enable_o(oe_o), .comparator_bias_enable_o(bias_o)
	);
	// ==========================================
	// shared tasks
	function automatic logic [3:0] upd(input logic [3:0] old, input logic [3:0] msk, input logic b);
		return (old & ~msk) | ({4{b}} & msk);
	endfunction : upd
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	// request held until ack is sampled; only the watchdog ends a wait
	task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
		input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		check("ack", {31'h0, wb_ack_o}, 32'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb
	task automatic check_outs();
		check("meas", {20'h0, hi_o, lo_o, open_o}, {20'h0, e_hi, e_lo, e_hi & e_lo});
		check("fin", {28'h0, fin_o}, {28'h0, e_fin});
		check("sys", {24'h0, sf_o, ss_o}, {24'h0, e_sf, e_ss});
		check("clamp", {28'h0, cl_o}, {28'h0, e_cl});
		check("cmp", {27'h0, bias_o, oe_o}, {27'h0, e_bias, e_oe});
	endtask : check_outs
	// ==========================================
	// main sequence
	initial
	begin
		void'($urandom(32'h7d17));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		// comparator outputs off after reset
		check_outs();
		// bias set before any comparator enable
		wb(1'b1, pscc_pkg::SYS_OFS, 4'hf, 32'h0000_2000);
		e_bias = 1'b1;
		for (i = 0; i < 40; i++)
		begin
			d = $urandom;
			d[14:13] = i[1:0];
			if (i == 0)
				d[27:24] = 4'hf;
			if (i == 1)
				d[27:24] = 4'h0;
			// at most one channel on shared lines
			if (!$onehot(d[27:24]) || ((e_sf | e_ss) & ~d[27:24]) != 4'h0)
				d[11:10] = 2'b00;
			if (i % 5 == 4)
			begin
				// bias forced on whenever this system write enables the comparators
				d[13] = d[13] | d[8];
				wb(1'b1, pscc_pkg::SYS_OFS, 4'hf, d);
				e_bias = d[13];
				m = 4'hf;
			end
			else
			begin
				wb(1'b1, pscc_pkg::CHAN_OFS, 4'hf, d);
				m = d[27:24];
				e_hi = upd(e_hi, m, d[14]);
				e_lo = upd(e_lo, m, d[13]);
				e_fin = upd(e_fin, m, d[12]);
				e_sf = upd(e_sf, m, d[11]);
				e_ss = upd(e_ss, m, d[10]);
			end
			e_cl = upd(e_cl, m, d[9]);
			e_oe = upd(e_oe, m, d[8]);
			@(negedge clk_i);
			check_outs();
			ch = 2'($urandom_range(3, 0));
			wb(1'b1, pscc_pkg::RDSEL_OFS, 4'h1, {30'h0, ch});
			wb(1'b0, pscc_pkg::CHAN_OFS, 4'hf, 32'h0);
			check("rd_chan", {25'h0, rd[14:8]}, {25'h0, e_hi[ch], e_lo[ch], e_fin[ch],
				e_sf[ch], e_ss[ch], e_cl[ch], e_oe[ch]});
			wb(1'b0, pscc_pkg::SYS_OFS, 4'hf, 32'h0);
			check("rd_sys", {29'h0, rd[13], rd[9:8]}, {29'h0, e_bias, e_cl[ch], e_oe[ch]});
		end
		// unmapped place and missing byte lane leave state alone
		wb(1'b1, 4'hc, 4'hf, 32'h0f00_7f00);
		wb(1'b0, 4'hc, 4'hf, 32'h0);
		check("rd_unmapped", rd, 32'h0);
		wb(1'b1, pscc_pkg::CHAN_OFS, 4'hd, 32'h0f00_7f00);
		@(negedge clk_i);
		check_outs();
		// without the channel lane no channel is addressed
		wb(1'b1, pscc_pkg::CHAN_OFS, 4'h7, 32'h0f00_7f00);
		@(negedge clk_i);
		check_outs();
		// bias, clamps and comparators on, then reset in mid-run
		wb(1'b1, pscc_pkg::SYS_OFS, 4'hf, 32'h0000_2300);
		e_bias = 1'b1;
		e_cl = 4'hf;
		e_oe = 4'hf;
		@(negedge clk_i);
		check_outs();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		e_hi = 4'hf;
		e_lo = 4'hf;
		e_fin = 4'h0;
		e_sf = 4'h0;
		e_ss = 4'h0;
		e_cl = 4'h0;
		e_oe = 4'h0;
		e_bias = 1'b0;
		@(negedge clk_i);
		check_outs();
		wb(1'b0, pscc_pkg::CHAN_OFS, 4'hf, 32'h0);
		check("rd_reset", {25'h0, rd[14:8]}, {25'h0, 7'h60});
		conclude();
	end
	initial
	begin
		#160000;
		failures++;
		conclude();
	end
endmodule : pscc_top_tb_top
`default_nettype wire
